// >>> design/ssp_defs.svh
// Offsets, encodings and reset values for the socket status and power pin logic
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ==========================================
// Register byte offsets (APB, one word each)
`define SSP_OFF_CFG_A   12'h000
`define SSP_OFF_CFG_B   12'h004
`define SSP_OFF_GCTL    12'h008
`define SSP_OFF_PWR     12'h00C
`define SSP_OFF_STATUS  12'h010
`define SSP_OFF_WAKE    12'h014

// ==========================================
// Reset values
`define SSP_RST_CFG     8'h00
`define SSP_RST_GCTL    4'h0
`define SSP_RST_PWR     8'h00

// ==========================================
// Power select encodings
`define SSP_SEL_OFF     2'h0
`define SSP_VCC_3V3     2'h1
`define SSP_VCC_5V      2'h2
`define SSP_VPP_VCC     2'h1
`define SSP_VPP_PROGRAMMING_ENABLE     2'h2
`define SSP_SEL_BOTH    2'h3

// ==========================================
// Serial frame
`define SSP_FRAME_BITS  8
`define SSP_FRAME_LAST  3'h7
`define SSP_FRAME_END   3'h0

`endif

// >>> design/ssp_pkg.sv
// Types shared by the socket status and power pin logic
package ssp_pkg;

    // ==========================================
    // Card interface modes
    typedef enum logic [1:0] {
        SSP_MODE_MEM = 2'h0,
        SSP_MODE_IO  = 2'h1,
        SSP_MODE_CB  = 2'h2
    } ssp_mode_t;

    // ==========================================
    // Serial power interface states
    typedef enum logic [2:0] {
        SSP_ST_IDLE  = 3'h1,
        SSP_ST_SHIFT = 3'h2,
        SSP_ST_LATCH = 3'h4
    } ssp_ser_st_t;

    // ==========================================
    // Register contents
    typedef struct packed {
        logic      cd_pullup;
        logic      vs_pull_data;
        logic      pme_en;
        logic      ring_en;
        logic      spkr_en;
        logic      bvd2_led;
        ssp_mode_t mode;
    } ssp_sock_cfg_t;

    typedef struct packed {
        logic act_b_mux;
        logic act_a_mode;
        logic parallel_irq_mode;
        logic parallel_power_mode;
    } ssp_gctl_t;

    typedef struct packed {
        logic [1:0] b_vpp;
        logic [1:0] b_vcc;
        logic [1:0] a_vpp;
        logic [1:0] a_vcc;
    } ssp_pwr_t;

    typedef struct packed {
        logic [1:0] vs_code;
        logic       led;
        logic       audio;
        logic       cb_stschg;
        logic       ring;
        logic       stschg;
        logic       batt_warn;
        logic       batt_dead;
        logic       valid;
    } ssp_sock_stat_t;

    // Pins crossing into the clock domain
    typedef struct packed {
        logic       aux;
        logic       grst_n;
        logic       pclk;
        logic [1:0] vs2;
        logic [1:0] vs1;
        logic [1:0] bvd2;
        logic [1:0] bvd1;
    } ssp_sync_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        speaker;
        logic        led;
        logic        pme;
        logic [1:0]  vs_pu;
        logic        a5v_n;
        logic        a5v_oe;
        logic        data;
        logic        latch;
        logic        irq3;
        logic        irq3_oe;
        logic        irq9;
        logic        irq9_oe;
        logic        irq10;
        logic        irq10_oe;
    } ssp_out_t;

endpackage : ssp_pkg

// >>> design/ssp_pin_logic.sv
// Socket status pin decode, activity outputs and socket power pin control
// Function
// - Memory mode: BVD2 is battery warning
// - I/O mode: BVD2 is speaker or LED
// - CardBus mode: BVD2 pin is audio input
// - Memory mode: BVD1 is battery dead
// - I/O mode: BVD1 is status change
// - Ring enable bit makes BVD1 ring indicate
// - CardBus status change can raise PME
// - VS pins give voltage; pull-ups jointly controlled
// - Speaker driven only when socket enable set
// - LED shows disk activity from LED pins
// - Activity mode: LED shows socket A activity
// - Serial mode drives power data pin
// - Serial mode drives power latch pin
// - Parallel: socket A 5V enable, exclusive
// - A 3.3V enable parallel only, else IRQ3
// - Parallel: socket B enables, never both
// - Socket A VPP-VCC enable, else IRQ9
// - Socket B VPP-VCC enable, else IRQ10
// - Global reset clears wake in D3cold with aux power
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"

module ssp_pin_logic
    import ssp_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,

    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,

    // Socket status pins, index 0 is socket A
    input  wire logic [1:0]  bvd1,
    input  wire logic [1:0]  bvd2,
    input  wire logic [1:0]  vs1,
    input  wire logic [1:0]  vs2,
    output logic      [1:0]  vs_pullup_en,

    // Card access activity from the bridge
    input  wire logic [1:0]  sock_access,

    // Activity outputs
    output logic             speaker_output,
    output logic             socket_a_activity,

    // Power management
    input  wire logic        g_rst_n_pin,
    input  wire logic        aux_present,
    input  wire logic        d3_cold,
    output logic             pme,

    // Interrupt requests for the shared pins
    input  wire logic        irq3_req,
    input  wire logic        irq9_req,
    input  wire logic        irq10_req,

    // Power clock pin, shared with socket A 5V enable
    input  wire logic        power_serial_clock,
    output logic             sock_a_5v_enable_n,
    output logic             sock_a_5v_oe,

    // Serial data and latch pins, shared with socket B enables
    output logic             power_serial_data,
    output logic             power_serial_latch,

    // IRQ pins shared with parallel power enables
    output logic             irq3_pin,
    output logic             irq3_pin_oe,
    output logic             irq9_pin,
    output logic             irq9_pin_oe,
    output logic             irq10_pin,
    output logic             irq10_pin_oe
);

    // ==========================================
    // State
    // One packed struct: synchronisers, registers, serial
    // engine and registered outputs
    typedef struct packed {
        ssp_sync_t           s1;
        ssp_sync_t           s2;
        logic                clk_prev;
        ssp_sock_cfg_t [1:0] cfg;
        ssp_gctl_t           gctl;
        ssp_pwr_t            pwr;
        logic [1:0]          wake;
        logic                pend;
        ssp_ser_st_t         st;
        logic [2:0]          bitn;
        logic [7:0]          shreg;
        ssp_out_t            o;
    } ssp_state_t;

    ssp_state_t s_q;
    ssp_state_t s_d;

    // Drop an illegal "both" select so two rails never enable together
    // Code 3 would turn both rails on, so it counts as off
    function automatic logic [1:0] ssp_resolve(input logic [1:0] sel);
        ssp_resolve = (sel == `SSP_SEL_BOTH) ? `SSP_SEL_OFF : sel;
    endfunction : ssp_resolve

    // ==========================================
    // Next state
    always_comb begin
        ssp_sock_stat_t [1:0] stat;
        ssp_pwr_t             res;
        logic [1:0]           wake_ev;
        logic [1:0]           wake_clr;
        logic                 spk;
        logic                 led_ind;
        logic                 rise;
        logic                 wr;
        logic                 grst;
        stat     = '0;
        res      = '0;
        wake_ev  = '0;
        wake_clr = '0;
        spk      = 1'b0;
        led_ind  = 1'b0;
        rise     = 1'b0;
        wr       = 1'b0;
        grst     = 1'b0;
        s_d      = s_q;

        // Two-flop synchronisers for pins
        s_d.s1.aux    = aux_present;
        s_d.s1.grst_n = g_rst_n_pin;
        s_d.s1.pclk   = power_serial_clock;
        s_d.s1.vs2    = vs2;
        s_d.s1.vs1    = vs1;
        s_d.s1.bvd2   = bvd2;
        s_d.s1.bvd1   = bvd1;
        s_d.s2        = s_q.s1;
        s_d.clk_prev  = s_q.s2.pclk;
        // Reference clock is far slower than mclk, so each
        // synced rising edge is seen exactly once
        rise = s_q.s2.pclk & ~s_q.clk_prev;

        // ======================================
        // Per-socket status decode
        for (int i = 0; i < 2; i++) begin
            stat[i].valid   = 1'b1;
            stat[i].vs_code = {s_q.s2.vs2[i], s_q.s2.vs1[i]};
            case (s_q.cfg[i].mode)
                SSP_MODE_MEM: begin
                    stat[i].batt_warn = ~s_q.s2.bvd2[i];
                    stat[i].batt_dead = ~s_q.s2.bvd1[i];
                end
                SSP_MODE_IO: begin
                    if (s_q.cfg[i].bvd2_led) begin
                        stat[i].led = ~s_q.s2.bvd2[i];
                    end else begin
                        stat[i].audio = ~s_q.s2.bvd2[i];
                    end
                    if (s_q.cfg[i].ring_en) begin
                        stat[i].ring = ~s_q.s2.bvd1[i];
                    end else begin
                        stat[i].stschg = ~s_q.s2.bvd1[i];
                    end
                end
                SSP_MODE_CB: begin
                    stat[i].audio     = s_q.s2.bvd2[i];
                    stat[i].cb_stschg = s_q.s2.bvd1[i];
                end
                default: begin
                    stat[i].valid = 1'b0;
                end
            endcase
            // Wake follows the level, so a held ring or status
            // change re-arms the sticky bit after a software clear
            wake_ev[i] = s_q.cfg[i].pme_en
                       & (stat[i].ring | stat[i].cb_stschg);
            // Two enabled cards mix as exclusive-or of their binary audio
            spk     = spk ^ (s_q.cfg[i].spkr_en & stat[i].audio);
            led_ind = led_ind | stat[i].led;
            s_d.o.vs_pu[i] = s_q.cfg[i].vs_pull_data
                           & s_q.cfg[i].cd_pullup;
        end

        // ======================================
        // APB slave: answer one cycle after setup
        // Zero wait states: setup decodes, access edge commits;
        // a write to an unmapped offset is dropped
        wr = psel & penable & s_q.o.pready & pwrite & ~s_q.o.pslverr;
        s_d.o.pready  = 1'b0;
        s_d.o.pslverr = 1'b0;
        if (psel & ~penable) begin
            s_d.o.pready = 1'b1;
            s_d.o.prdata = '0;
            case (paddr)
                `SSP_OFF_CFG_A:  s_d.o.prdata = 32'(s_q.cfg[0]);
                `SSP_OFF_CFG_B:  s_d.o.prdata = 32'(s_q.cfg[1]);
                `SSP_OFF_GCTL:   s_d.o.prdata = 32'(s_q.gctl);
                `SSP_OFF_PWR:    s_d.o.prdata = 32'({s_q.st != SSP_ST_IDLE,
                                                     s_q.pend, s_q.pwr});
                `SSP_OFF_STATUS: s_d.o.prdata = {6'h00, stat[1], 6'h00, stat[0]};
                `SSP_OFF_WAKE:   s_d.o.prdata = 32'(s_q.wake);
                default:         s_d.o.pslverr = 1'b1;
            endcase
        end

        // ======================================
        // Serial power interface, stepped on power clock rising edges
        // Eight bits, most significant first, then one latch period
        // with data low; a write during a frame waits its turn
        case (s_q.st)
            SSP_ST_IDLE: begin
                s_d.o.latch = 1'b0;
                if (s_q.pend & rise & ~s_q.gctl.parallel_power_mode) begin
                    res.a_vcc = ssp_resolve(s_q.pwr.a_vcc);
                    res.a_vpp = ssp_resolve(s_q.pwr.a_vpp);
                    res.b_vcc = ssp_resolve(s_q.pwr.b_vcc);
                    res.b_vpp = ssp_resolve(s_q.pwr.b_vpp);
                    s_d.shreg  = res;
                    s_d.o.data = res[`SSP_FRAME_BITS-1];
                    s_d.bitn   = `SSP_FRAME_LAST;
                    s_d.pend   = 1'b0;
                    s_d.st     = SSP_ST_SHIFT;
                end
            end
            SSP_ST_SHIFT: begin
                if (rise) begin
                    if (s_q.bitn == `SSP_FRAME_END) begin
                        s_d.o.data  = 1'b0;
                        s_d.o.latch = 1'b1;
                        s_d.st      = SSP_ST_LATCH;
                    end else begin
                        s_d.shreg  = {s_q.shreg[`SSP_FRAME_BITS-2:0], 1'b0};
                        s_d.o.data = s_q.shreg[`SSP_FRAME_BITS-2];
                        s_d.bitn   = s_q.bitn - 3'h1;
                    end
                end
            end
            SSP_ST_LATCH: begin
                if (rise) begin
                    s_d.o.latch = 1'b0;
                    s_d.st      = SSP_ST_IDLE;
                end
            end
            default: begin
                s_d.o.latch = 1'b0;
                s_d.st      = SSP_ST_IDLE;
            end
        endcase
        // Switching to parallel mode abandons a frame in flight
        if (s_q.gctl.parallel_power_mode) begin
            s_d.st      = SSP_ST_IDLE;
            s_d.o.latch = 1'b0;
        end

        // ======================================
        // Register writes; a write landing with a frame start keeps pend set
        if (wr) begin
            case (paddr)
                `SSP_OFF_CFG_A: s_d.cfg[0] = ssp_sock_cfg_t'(pwdata[7:0]);
                `SSP_OFF_CFG_B: s_d.cfg[1] = ssp_sock_cfg_t'(pwdata[7:0]);
                `SSP_OFF_GCTL:  s_d.gctl   = ssp_gctl_t'(pwdata[3:0]);
                `SSP_OFF_PWR: begin
                    s_d.pwr  = ssp_pwr_t'(pwdata[7:0]);
                    s_d.pend = 1'b1;
                end
                `SSP_OFF_WAKE:  wake_clr   = pwdata[1:0];
                default: begin
                end
            endcase
        end

        // ======================================
        // Wake context: new event beats a software clear
        // Global reset only counts with aux power in D3cold;
        // otherwise the wake context survives it
        grst = ~s_q.s2.grst_n & d3_cold & s_q.s2.aux;
        s_d.wake = (s_q.wake & ~wake_clr) | wake_ev;
        if (grst) begin
            s_d.wake = '0;
        end
        s_d.o.pme = |s_d.wake;

        // ======================================
        // Activity outputs
        s_d.o.speaker = spk;
        if (s_q.gctl.act_a_mode) begin
            s_d.o.led = sock_access[0]
                      | (s_q.gctl.act_b_mux & sock_access[1]);
        end else begin
            s_d.o.led = led_ind;
        end

        // ======================================
        // Shared power and interrupt pins
        // Parallel power mode owns the shared pins even when
        // parallel interrupt mode is also set
        res.a_vcc = ssp_resolve(s_q.pwr.a_vcc);
        res.a_vpp = ssp_resolve(s_q.pwr.a_vpp);
        res.b_vcc = ssp_resolve(s_q.pwr.b_vcc);
        res.b_vpp = ssp_resolve(s_q.pwr.b_vpp);
        if (s_q.gctl.parallel_power_mode) begin
            s_d.o.a5v_oe   = 1'b1;
            s_d.o.a5v_n    = ~(res.a_vcc == `SSP_VCC_5V);
            s_d.o.data     = ~(res.b_vcc == `SSP_VCC_3V3);
            s_d.o.latch    = ~(res.b_vcc == `SSP_VCC_5V);
            s_d.o.irq3     = ~(res.a_vcc == `SSP_VCC_3V3);
            s_d.o.irq3_oe  = 1'b1;
            s_d.o.irq9     = (res.a_vpp == `SSP_VPP_VCC);
            s_d.o.irq9_oe  = 1'b1;
            s_d.o.irq10    = (res.b_vpp == `SSP_VPP_VCC);
            s_d.o.irq10_oe = 1'b1;
        end else begin
            s_d.o.a5v_oe   = 1'b0;
            s_d.o.a5v_n    = 1'b1;
            s_d.o.irq3     = irq3_req;
            s_d.o.irq3_oe  = s_q.gctl.parallel_irq_mode;
            s_d.o.irq9     = irq9_req;
            s_d.o.irq9_oe  = s_q.gctl.parallel_irq_mode;
            s_d.o.irq10    = irq10_req;
            s_d.o.irq10_oe = s_q.gctl.parallel_irq_mode;
        end
    end

    // ==========================================
    // State register
    // The socket A 5V enable is active low, so reset parks it off; the
    // global reset sync flops start inactive to avoid a false clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q            <= '0;
            s_q.s1.grst_n  <= 1'b1;
            s_q.s2.grst_n  <= 1'b1;
            s_q.cfg[0]     <= ssp_sock_cfg_t'(`SSP_RST_CFG);
            s_q.cfg[1]     <= ssp_sock_cfg_t'(`SSP_RST_CFG);
            s_q.gctl       <= ssp_gctl_t'(`SSP_RST_GCTL);
            s_q.pwr        <= ssp_pwr_t'(`SSP_RST_PWR);
            s_q.st         <= SSP_ST_IDLE;
            s_q.o.a5v_n    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs straight from the state register
    // IRQ pins carry their request even while their enable is low
    assign prdata             = s_q.o.prdata;
    assign pready             = s_q.o.pready;
    assign pslverr            = s_q.o.pslverr;
    assign vs_pullup_en       = s_q.o.vs_pu;
    assign speaker_output     = s_q.o.speaker;
    assign socket_a_activity  = s_q.o.led;
    assign pme                = s_q.o.pme;
    assign sock_a_5v_enable_n = s_q.o.a5v_n;
    assign sock_a_5v_oe       = s_q.o.a5v_oe;
    assign power_serial_data  = s_q.o.data;
    assign power_serial_latch = s_q.o.latch;
    assign irq3_pin           = s_q.o.irq3;
    assign irq3_pin_oe        = s_q.o.irq3_oe;
    assign irq9_pin           = s_q.o.irq9;
    assign irq9_pin_oe        = s_q.o.irq9_oe;
    assign irq10_pin          = s_q.o.irq10;
    assign irq10_pin_oe       = s_q.o.irq10_oe;

endmodule : ssp_pin_logic
`default_nettype wire

// >>> tb/ssp_pin_logic_chk.sv
// Assertion checker for the socket status and power pin logic
`timescale 1ns/1ps
`default_nettype none

module ssp_pin_logic_chk (
    // Clock, reset and APB
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Power and shared pins
    input wire logic        sock_a_5v_enable_n,
    input wire logic        sock_a_5v_oe,
    input wire logic        power_serial_data,
    input wire logic        power_serial_latch,
    input wire logic        irq3_pin,
    input wire logic        irq3_pin_oe,
    input wire logic        irq9_pin_oe,
    input wire logic        irq10_pin_oe,
    input wire logic        pme
);
    // ==========================================
    // APB timing
    a_apb_answer: assert property (@(posedge mclk) disable iff (!rst_n)
        psel && !penable |=> pready) else $error("no pready after setup");
    a_ready_one: assert property (@(posedge mclk) disable iff (!rst_n)
        pready |=> !pready) else $error("pready longer than one cycle");
    a_err_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");

    // ==========================================
    // Parallel power pins
    a_a_excl: assert property (@(posedge mclk) disable iff (!rst_n)
        sock_a_5v_oe |-> sock_a_5v_enable_n || irq3_pin) else $error("A 5V and 3.3V both on");
    a_b_excl: assert property (@(posedge mclk) disable iff (!rst_n)
        sock_a_5v_oe |-> power_serial_data || power_serial_latch) else $error("B 5V and 3.3V both on");
    a_par_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        sock_a_5v_oe |-> irq3_pin_oe && irq9_pin_oe && irq10_pin_oe) else $error("enable pin not driven");

    // ==========================================
    // Serial frame end and reset state
    a_latch_data: assert property (@(posedge mclk) disable iff (!rst_n)
        !sock_a_5v_oe && $rose(power_serial_latch) |-> !power_serial_data) else $error("data high at latch");
    // Reset itself is the cause here, so it cannot disable the check
    a_rst_state: assert property (@(posedge mclk)
        !rst_n |=> sock_a_5v_enable_n && !pme && !pready) else $error("bad state after reset");
endmodule : ssp_pin_logic_chk

bind ssp_pin_logic ssp_pin_logic_chk u_chk (.*);

`default_nettype wire

// >>> tb/ssp_pwr_switch_model.sv
// Socket power switch model: reference clock and serial receiver
`timescale 1ns/1ps
`default_nettype none

module ssp_pwr_switch_model #(
    parameter int HALF_NS = 5000
) (
    // Serial power interface
    output logic       power_serial_clock,
    input  wire logic  power_serial_data,
    input  wire logic  power_serial_latch,
    // Received word and frame count
    output logic [7:0] latched,
    output int         frames
);
    logic [7:0] sr_q;

    initial begin // Free-running 100 kHz reference
        power_serial_clock = 1'b0;
        latched = 8'h00;
        frames = 0;
        forever #(HALF_NS) power_serial_clock = ~power_serial_clock;
    end
    // Mid-period sampling keeps clear of the data update
    always @(negedge power_serial_clock) begin
        sr_q <= {sr_q[6:0], power_serial_data};
    end
    always @(posedge power_serial_latch) begin
        latched <= sr_q;
        frames <= frames + 1;
    end
endmodule : ssp_pwr_switch_model

`default_nettype wire

// >>> tb/ssp_pin_logic_tb.sv
// Testbench for the socket status and power pin logic
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.svh"

module ssp_pin_logic_tb;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  bvd1, bvd2, vs1, vs2, vs_pullup_en, sock_access;
    logic        speaker_output, socket_a_activity, g_rst_n_pin, aux_present, d3_cold, pme;
    logic        irq3_req, irq9_req, irq10_req, power_serial_clock, sock_a_5v_enable_n, sock_a_5v_oe;
    logic        power_serial_data, power_serial_latch, irq3_pin, irq3_pin_oe, irq9_pin, irq9_pin_oe;
    logic        irq10_pin, irq10_pin_oe;
    logic [7:0]  latched;
    int          frames, n_mismatch, checked, f0, n;
    // Status cases: config, pins {vs2,vs1,bvd2,bvd1}, mask, expected
    logic [7:0]  t_cfg [7] = '{8'h00, 8'h01, 8'h05, 8'h11, 8'h02, 8'h00, 8'h03};
    logic [3:0]  t_pin [7] = '{4'hC, 4'hC, 4'hD, 4'hE, 4'hF, 4'h7, 4'hF};
    logic [9:0]  t_msk [7] = '{10'h007, 10'h048, 10'h080, 10'h010, 10'h060, 10'h307, 10'h001};
    logic [9:0]  t_exp [7] = '{10'h007, 10'h048, 10'h080, 10'h010, 10'h060, 10'h101, 10'h000};
    logic [7:0]  t_pwr [3] = '{8'h15, 8'h62, 8'hFF};
    logic [5:0]  t_par [3] = '{6'h26, 6'h19, 6'h3C};

    ssp_pin_logic uut (.*);
    ssp_pwr_switch_model u_sw (.*);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ==========================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic test_done();
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    // One idle cycle after each transfer keeps drivers single-assigned
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic wait_n(input int c);
        repeat (c) @(posedge mclk);
    endtask : wait_n

    // ==========================================
    // Sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, sock_access} = '0;
        {bvd1, bvd2, vs1, vs2} = '1;
        {irq3_req, irq9_req, irq10_req, d3_cold} = '0;
        {g_rst_n_pin, aux_present} = 2'b11;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, `SSP_OFF_PWR, 32'h0);
        chk("pwr reset", 32'h0, rd);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped err", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        for (int i = 0; i < 2; i++) begin
            f0 = frames;
            apb(1'b1, `SSP_OFF_PWR, i ? 32'h0000_00C3 : 32'h0000_005A);
            for (n = 0; frames == f0 && n < 40000; n++) @(posedge mclk);
            if (n >= 40000) begin
                n_mismatch++;
                test_done();
            end
            chk("frame", i ? 32'h0 : 32'h5A, {24'h0, latched});
        end
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `SSP_OFF_CFG_A, {24'h0, t_cfg[i]});
            {vs2[0], vs1[0], bvd2[0], bvd1[0]} <= t_pin[i];
            wait_n(5);
            apb(1'b0, `SSP_OFF_STATUS, 32'h0);
            chk("status", {22'h0, t_exp[i]}, rd & {22'h0, t_msk[i]});
        end
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `SSP_OFF_CFG_A, {24'h0, k[1:0], 6'h00});
            wait_n(3);
            chk("pullup", k == 3, vs_pullup_en[0]);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `SSP_OFF_CFG_A, {28'h0, k[0], 3'h2});
            wait_n(5);
            chk("speaker", k, speaker_output);
        end
        apb(1'b1, `SSP_OFF_CFG_A, 32'h5);
        for (int k = 0; k < 2; k++) begin
            bvd2[0] <= k[0];
            wait_n(5);
            chk("led", !k, socket_a_activity);
        end
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `SSP_OFF_GCTL, k == 2 ? 32'hC : 32'h4);
            sock_access <= k == 0 ? 2'b01 : 2'b10;
            wait_n(3);
            chk("activity", k != 1, socket_a_activity);
        end
        apb(1'b1, `SSP_OFF_GCTL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `SSP_OFF_PWR, {24'h0, t_pwr[i]});
            wait_n(3);
            chk("parallel", {1'b1, t_par[i]}, {sock_a_5v_oe, sock_a_5v_enable_n, irq3_pin,
                power_serial_data, power_serial_latch, irq9_pin, irq10_pin});
        end
        apb(1'b1, `SSP_OFF_GCTL, 32'h2);
        for (int k = 0; k < 2; k++) begin
            {irq3_req, irq9_req, irq10_req} <= {3{k[0]}};
            wait_n(3);
            chk("irq mode", {4'b0111, {3{k[0]}}}, {sock_a_5v_oe, irq3_pin_oe, irq9_pin_oe,
                irq10_pin_oe, irq3_pin, irq9_pin, irq10_pin});
        end
        apb(1'b1, `SSP_OFF_CFG_A, 32'h22);
        for (int k = 0; k < 3; k++) begin
            bvd1[0] <= 1'b1;
            wait_n(5);
            bvd1[0] <= 1'b0;
            wait_n(5);
            chk("pme set", 1, pme);
            {g_rst_n_pin, aux_present, d3_cold} <= k == 0 ? 3'b010 : k == 1 ? 3'b001 : 3'b011;
            wait_n(8);
            chk("global reset", k != 2, pme);
            {g_rst_n_pin, aux_present, d3_cold} <= 3'b110;
            apb(1'b1, `SSP_OFF_WAKE, 32'h3);
            wait_n(2);
            chk("wake clear", 0, pme);
        end
        test_done();
    end
endmodule : ssp_pin_logic_tb

`default_nettype wire
